// ===== verilog/ivr_pkg.sv
// Constants and helper functions for the interrupt vector relocation block
`default_nettype none
package ivr_pkg;
    // ----------------------------------------------------------------
    // Register map and widths
    // ----------------------------------------------------------------
    localparam int unsigned IVR_ADDR_W     = 6;             // I/O address width
    localparam int unsigned IVR_DATA_W     = 8;             // Register data width
    localparam int unsigned IVR_PC_W       = 12;            // Word address width of flash
    localparam int unsigned IVR_NUM_W      = 5;             // Vector number width
    localparam logic [5:0]  IVR_GIC_OFS    = 6'h20;         // general_interrupt_control
    localparam logic [5:0]  IVR_STAT_OFS   = 6'h21;         // Relocation status, read only
    localparam int unsigned IVR_CE_BIT     = 0;             // vector_change_enable position
    localparam int unsigned IVR_SEL_BIT    = 1;             // vector_table_select position
    localparam logic [7:0]  IVR_GIC_RST    = 8'h00;         // Both bits clear after reset
    localparam logic [7:0]  IVR_RD_NONE    = 8'h00;         // Unmapped or reserved reads
    // ----------------------------------------------------------------
    // Timing: change window of four cycles at 250 MHz (4 ns)
    // ----------------------------------------------------------------
    localparam int unsigned IVR_CLK_PS     = 4000;          // Clock period in ps
    localparam int unsigned IVR_CE_CYCLES  = 4;             // Change-enable lifetime, cycles
    localparam logic [2:0]  IVR_CE_LOAD    = 3'(IVR_CE_CYCLES);
    localparam logic [2:0]  IVR_CE_LAST    = 3'h1;          // Final armed cycle
    // ----------------------------------------------------------------
    // Flash layout in words
    // ----------------------------------------------------------------
    localparam logic [11:0] IVR_APP_BASE   = 12'h000;       // Start of program flash
    localparam logic [11:0] IVR_BOOT_1K    = 12'hc00;       // 2K-byte boot section start
    localparam logic [11:0] IVR_BOOT_512   = 12'he00;       // 1K-byte boot section start
    localparam logic [11:0] IVR_BOOT_256   = 12'hf00;       // 512-byte boot section start
    localparam logic [11:0] IVR_BOOT_128   = 12'hf80;       // 256-byte boot section start
    localparam logic [1:0]  IVR_SZ_1K      = 2'h0;          // boot_size_fuses codes
    localparam logic [1:0]  IVR_SZ_512     = 2'h1;
    localparam logic [1:0]  IVR_SZ_256     = 2'h2;
    localparam logic [1:0]  IVR_SZ_128     = 2'h3;
    localparam logic        IVR_FUSE_PROG  = 1'b0;          // A fuse reads zero when programmed

    // Boot section start word address from the boot size fuses
    function automatic logic [11:0] ivr_boot_start(input logic [1:0] sz);
        logic [11:0] s;
        s = IVR_BOOT_128;
        unique case (sz)
            IVR_SZ_1K:  s = IVR_BOOT_1K;
            IVR_SZ_512: s = IVR_BOOT_512;
            IVR_SZ_256: s = IVR_BOOT_256;
            IVR_SZ_128: s = IVR_BOOT_128;
        endcase
        return s;
    endfunction : ivr_boot_start
endpackage : ivr_pkg
`default_nettype wire

// ===== verilog/ivr_vector_map.sv
// Vector and reset address generator for the relocation block
`timescale 1ns/1ns
`default_nettype none
module ivr_vector_map
    import ivr_pkg::*;
(
    input  wire  logic                 clock_i,        // System clock
    input  wire  logic                 rst_i,          // Synchronous reset, high
    input  wire  logic                 sel_i,          // Current table placement
    input  wire  logic [1:0]           boot_size_i,    // Boot size fuse code
    input  wire  logic                 boot_rst_i,     // Boot reset fuse, 0 = programmed
    input  wire  logic [IVR_NUM_W-1:0] irq_num_i,      // Vector number, 1 = first
    output var   logic [IVR_PC_W-1:0]  vector_addr_o,  // Registered vector address
    output var   logic [IVR_PC_W-1:0]  reset_addr_o    // Registered reset address
);
    import ivr_pkg::*;

    typedef struct packed {
        logic [IVR_PC_W-1:0] vec;
        logic [IVR_PC_W-1:0] rst;
    } ivr_map_t;

    ivr_map_t map_reg;
    ivr_map_t map_next;
    logic [IVR_PC_W-1:0] boot_base;

    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    // Relocated vectors keep their table offset on top of the boot start
    always_comb begin
        boot_base    = ivr_boot_start(boot_size_i);
        map_next.vec = (sel_i ? boot_base : IVR_APP_BASE)
                       + IVR_PC_W'(irq_num_i);
        map_next.rst = (boot_rst_i == IVR_FUSE_PROG) ? boot_base : IVR_APP_BASE;
    end

    // Registered so dispatch sees a clean word
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            map_reg <= '0;
        end else begin
            map_reg <= map_next;
        end
    end

    assign vector_addr_o = map_reg.vec;
    assign reset_addr_o  = map_reg.rst;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // The first cycle after release still shows the reset word, so it is skipped
    vec_offset_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(rst_i) |->
        (vector_addr_o == $past(sel_i ? ivr_boot_start(boot_size_i) : IVR_APP_BASE)
             + IVR_PC_W'($past(irq_num_i))))
        else $error("vector address not base plus vector number");
    reset_boot_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (boot_rst_i == IVR_FUSE_PROG && boot_size_i == IVR_SZ_1K) ##1
        $stable(boot_rst_i) && $stable(boot_size_i) |-> reset_addr_o == IVR_BOOT_1K)
        else $error("boot reset address wrong");
endmodule : ivr_vector_map
`default_nettype wire

// ===== verilog/ivr_top.sv
// Interrupt vector relocation control: select register, change guard, lock masking
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module ivr_top
    import ivr_pkg::*;
#(
    parameter int unsigned PC_W   = ivr_pkg::IVR_PC_W,    // Flash word address width
    parameter int unsigned ADDR_W = ivr_pkg::IVR_ADDR_W   // Register address width
) (
    input  wire  logic                          clock_i,         // System clock, 250 MHz
    input  wire  logic                          rst_i,           // Synchronous reset, high
    input  wire  logic [ivr_pkg::IVR_ADDR_W-1:0] reg_addr_i,     // Register address
    input  wire  logic [ivr_pkg::IVR_DATA_W-1:0] reg_wdata_i,    // Write data
    input  wire  logic                          reg_wr_i,        // Write strobe
    input  wire  logic                          reg_rd_i,        // Read strobe
    output var   logic [ivr_pkg::IVR_DATA_W-1:0] reg_rdata_o,    // Read data, next cycle
    input  wire  logic [1:0]                    boot_size_fuses_i,        // Boot size code
    input  wire  logic                          boot_reset_select_fuse_i, // 0 = programmed
    input  wire  logic                          app_section_boot_lock_i,  // 0 = programmed
    input  wire  logic                          boot_section_boot_lock_i, // 0 = programmed
    input  wire  logic [ivr_pkg::IVR_PC_W-1:0]  pc_i,            // Executing word address
    input  wire  logic                          instr_done_i,    // Instruction retires
    input  wire  logic                          global_ie_i,     // Core global enable flag
    input  wire  logic [ivr_pkg::IVR_NUM_W-1:0] irq_num_i,       // Vector number to map
    output var   logic                          irq_enable_o,    // Interrupts may be taken
    output var   logic [ivr_pkg::IVR_PC_W-1:0]  irq_vector_addr_o, // Vector word address
    output var   logic [ivr_pkg::IVR_PC_W-1:0]  reset_addr_o     // Reset word address
);
    import ivr_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (PC_W != IVR_PC_W) begin : g_pc_chk
        $error("PC_W must match the flash word address width");
    end
    if (ADDR_W != IVR_ADDR_W) begin : g_addr_chk
        $error("ADDR_W must match the register address width");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       sel;      // vector_table_select
        logic       ce;       // vector_change_enable
        logic [2:0] cnt;      // Cycles left in the change window
        logic       hold;     // Waiting for the instruction after the select write
        logic [7:0] rdata;    // Read data register
    } ivr_state_t;

    ivr_state_t st_reg;
    ivr_state_t st_next;

    logic       gic_wr;
    logic       arm_wr;
    logic       sel_wr;
    logic       in_boot;
    logic       seq_block;
    logic       lock_block;
    logic [7:0] gic_view;
    logic [7:0] stat_view;
    logic [PC_W-1:0] boot_base;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // A select write only counts while armed and with the enable bit written zero
    assign gic_wr  = reg_wr_i && (reg_addr_i == IVR_GIC_OFS);
    assign arm_wr  = gic_wr && reg_wdata_i[IVR_CE_BIT];
    assign sel_wr  = gic_wr && st_reg.ce && !reg_wdata_i[IVR_CE_BIT];

    // Section of the code now running
    assign boot_base = ivr_boot_start(boot_size_fuses_i);
    assign in_boot   = (pc_i >= boot_base);

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    // Blocking is combinational so it covers the very cycle of the arm write
    assign seq_block = arm_wr || st_reg.ce || st_reg.hold;

    // Lock masking depends on where code runs relative to the table
    assign lock_block =
        ( st_reg.sel && (app_section_boot_lock_i == IVR_FUSE_PROG) && !in_boot) ||
        (!st_reg.sel && (boot_section_boot_lock_i == IVR_FUSE_PROG) && in_boot);

    // The global flag passes through untouched; only the gate drops
    assign irq_enable_o = global_ie_i && !seq_block && !lock_block;

    // ----------------------------------------------------------------
    // Read views
    // ----------------------------------------------------------------
    always_comb begin
        gic_view = IVR_RD_NONE;
        gic_view[IVR_SEL_BIT] = st_reg.sel;
        gic_view[IVR_CE_BIT]  = st_reg.ce;
        stat_view = {2'h0, in_boot, st_reg.cnt, st_reg.hold, seq_block};
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Read data stand for one cycle only; idle cycles return zero
        st_next.rdata = IVR_RD_NONE;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                IVR_GIC_OFS:  st_next.rdata = gic_view;
                IVR_STAT_OFS: st_next.rdata = stat_view;
                default:      st_next.rdata = IVR_RD_NONE;
            endcase
        end

        // Change window counts down and drops the enable on its own
        if (st_reg.ce) begin
            st_next.cnt = st_reg.cnt - 3'h1;
            if (st_reg.cnt == IVR_CE_LAST) begin
                st_next.ce = 1'b0;
            end
        end

        // Hold ends once the instruction after the select write retires
        if (st_reg.hold && instr_done_i) begin
            st_next.hold = 1'b0;
        end

        // Select write: takes effect and closes the window at once
        if (sel_wr) begin
            st_next.sel  = reg_wdata_i[IVR_SEL_BIT];
            st_next.ce   = 1'b0;
            st_next.cnt  = 3'h0;
            st_next.hold = 1'b1;
        end else if (arm_wr) begin
            // Arming again restarts the window; select is not changed here
            st_next.ce  = 1'b1;
            st_next.cnt = IVR_CE_LOAD;
        end
    end

    // Single state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg     <= '0;
            st_reg.sel <= IVR_GIC_RST[IVR_SEL_BIT];
            st_reg.ce  <= IVR_GIC_RST[IVR_CE_BIT];
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;

    // ----------------------------------------------------------------
    // Vector address generation
    // ----------------------------------------------------------------
    ivr_vector_map u_map (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .sel_i         (st_reg.sel),
        .boot_size_i   (boot_size_fuses_i),
        .boot_rst_i    (boot_reset_select_fuse_i),
        .irq_num_i     (irq_num_i),
        .vector_addr_o (irq_vector_addr_o),
        .reset_addr_o  (reset_addr_o)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    arm_sets_ce_a: assert property (@(posedge clock_i) disable iff (rst_i)
        arm_wr && !sel_wr |=> st_reg.ce && st_reg.cnt == 3'h4)
        else $error("change enable not armed by its write");

    ce_lifetime_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (arm_wr && !sel_wr) ##1 (!gic_wr) [*4] |=>
        !st_reg.ce && st_reg.cnt == 3'h0 && (!seq_block || arm_wr || st_reg.hold))
        else $error("change window did not close after four cycles");

    ce_held_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (arm_wr && !sel_wr) ##1 (!gic_wr) [*3] |-> st_reg.ce)
        else $error("change enable dropped early");

    arm_block_a: assert property (@(posedge clock_i) disable iff (rst_i)
        arm_wr |-> !irq_enable_o)
        else $error("interrupt allowed in arm cycle");

    sel_update_a: assert property (@(posedge clock_i) disable iff (rst_i)
        sel_wr |=> st_reg.sel == $past(reg_wdata_i[IVR_SEL_BIT]) && !st_reg.ce && st_reg.hold)
        else $error("select write not applied");

    sel_guard_a: assert property (@(posedge clock_i) disable iff (rst_i)
        gic_wr && !st_reg.ce |=> $stable(st_reg.sel))
        else $error("select changed without arming");

    hold_release_a: assert property (@(posedge clock_i) disable iff (rst_i)
        st_reg.hold && !instr_done_i && !arm_wr |=> !irq_enable_o throughout st_reg.hold)
        else $error("interrupt allowed before instruction after select");

    app_lock_a: assert property (@(posedge clock_i) disable iff (rst_i)
        st_reg.sel && app_section_boot_lock_i == IVR_FUSE_PROG && pc_i < boot_base
        |-> !irq_enable_o)
        else $error("interrupt allowed in locked application code");

    boot_lock_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !st_reg.sel && boot_section_boot_lock_i == IVR_FUSE_PROG && pc_i >= boot_base
        |-> !irq_enable_o)
        else $error("interrupt allowed in locked boot code");

    ie_untouched_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !seq_block && !lock_block |-> irq_enable_o == global_ie_i)
        else $error("gate alters global enable");

    reset_clear_a: assert property (@(posedge clock_i)
        rst_i |=> !st_reg.sel && !st_reg.ce && !st_reg.hold)
        else $error("select or change enable set after reset");
endmodule : ivr_top
`default_nettype wire

// ===== dv/ivr_core_model.sv
// Behavioural core model: retires instructions and owns the global interrupt flag
`timescale 1ns/1ns
`default_nettype none
module ivr_core_model (
    input  wire logic clock_i,      // System clock
    input  wire logic rst_i,        // Synchronous reset, high
    input  wire logic run_i,        // Core executes instructions
    output var  logic instr_done_o, // One pulse per retired instruction
    output var  logic global_ie_o   // Global interrupt enable flag
);
    // ----------------------------------------------------------------
    // Retire pulses and status flag
    // ----------------------------------------------------------------
    // Two-cycle instructions, so a held run never gives a stuck-high retire
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            instr_done_o <= 1'b0;
            global_ie_o  <= 1'b0;
        end else begin
            instr_done_o <= run_i & ~instr_done_o;
            global_ie_o  <= 1'b1;                  // Only the core writes it
        end
    end
endmodule : ivr_core_model
`default_nettype wire

// ===== dv/interrupt_vector_relocation_test.sv
// Self-checking testbench for the interrupt vector relocation block
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_relocation_test;
    import ivr_pkg::*;
    logic        clock_i, rst_i, reg_wr_i, reg_rd_i, run;
    logic [5:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, d;
    logic [1:0]  boot_size_fuses_i;
    logic        boot_reset_select_fuse_i, app_section_boot_lock_i, boot_section_boot_lock_i;
    logic [11:0] pc_i, irq_vector_addr_o, reset_addr_o;
    logic [4:0]  irq_num_i;
    logic        instr_done_i, global_ie_i, irq_enable_o;
    logic [11:0] bstart [4];
    int          miscompares, n_compared;

    ivr_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .boot_size_fuses_i(boot_size_fuses_i),
        .boot_reset_select_fuse_i(boot_reset_select_fuse_i),
        .app_section_boot_lock_i(app_section_boot_lock_i),
        .boot_section_boot_lock_i(boot_section_boot_lock_i), .pc_i(pc_i),
        .instr_done_i(instr_done_i), .global_ie_i(global_ie_i), .irq_num_i(irq_num_i),
        .irq_enable_o(irq_enable_o), .irq_vector_addr_o(irq_vector_addr_o),
        .reset_addr_o(reset_addr_o));
    ivr_core_model core (.clock_i(clock_i), .rst_i(rst_i), .run_i(run),
        .instr_done_o(instr_done_i), .global_ie_o(global_ie_i));

    // ----------------------------------------------------------------
    // Clock and bus tasks
    // ----------------------------------------------------------------
    // Free-running 250 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // One-cycle write, taken at the second edge
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    // One-cycle read; data only stands in the following cycle
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Sample n cycles later, once settled
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // Wait for the post-select hold to end, bounded so a stuck hold still fails
    task automatic wait_enable();
        step(0);
        for (int i = 0; i < 8 && irq_enable_o !== 1'b1; i++) step(1);
        check("enable after hold", 16'(irq_enable_o), 16'h1);
    endtask : wait_enable

    // ----------------------------------------------------------------
    // Watchdog: the sequence needs well under a thousand cycles
    // ----------------------------------------------------------------
    initial begin
        #20000;
        miscompares++;
        $display("Watchdog expired");
        complete_run();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        miscompares = 0;
        n_compared  = 0;
        bstart = '{IVR_BOOT_1K, IVR_BOOT_512, IVR_BOOT_256, IVR_BOOT_128};
        rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 6'h00;
        reg_wdata_i = 8'h00;
        run = 1'b0;
        boot_size_fuses_i = IVR_SZ_1K;
        boot_reset_select_fuse_i = 1'b1;
        app_section_boot_lock_i = 1'b1;
        boot_section_boot_lock_i = 1'b1;
        pc_i = 12'h000;
        irq_num_i = 5'h01;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        // Reset state, unmapped read, unarmed and read-only writes
        rd(IVR_GIC_OFS, d);
        check("control after reset", 16'(d), 16'h0);
        check("reset address", 16'(reset_addr_o), 16'h0);
        rd(6'h3f, d);
        check("unmapped read", 16'(d), 16'h0);
        wr(IVR_STAT_OFS, 8'hff);
        wr(IVR_GIC_OFS, 8'h02);
        rd(IVR_GIC_OFS, d);
        check("unarmed select write", 16'(d), 16'h0);
        check("vector at flash start", 16'(irq_vector_addr_o), 16'h1);
        $display("test reset_and_guard done");
        // Arm and let the window lapse: blocked for four cycles after the write is taken
        wr(IVR_GIC_OFS, 8'h01);
        #1 check("blocked first cycle", 16'(irq_enable_o), 16'h0);
        for (int i = 0; i < 3; i++) begin
            step(1);
            check("blocked in window", 16'(irq_enable_o), 16'h0);
        end
        step(1);
        check("released after four", 16'(irq_enable_o), 16'h1);
        rd(IVR_GIC_OFS, d);
        check("enable self-cleared", 16'(d), 16'h0);
        $display("test window_timeout done");
        // Full relocation: hold lasts until an instruction retires
        wr(IVR_GIC_OFS, 8'h01);
        wr(IVR_GIC_OFS, 8'h02);
        for (int i = 0; i < 6; i++) begin
            step(1);
            check("hold without retire", 16'(irq_enable_o), 16'h0);
        end
        rd(IVR_STAT_OFS, d);
        check("status during hold", 16'(d), 16'h03);
        @(posedge clock_i);
        run <= 1'b1;
        wait_enable();
        rd(IVR_GIC_OFS, d);
        check("select set, enable clear", 16'(d), 16'h2);
        $display("test relocate done");
        // Vector and reset addresses for every boot size
        for (int s = 0; s < 4; s++) begin
            for (int n = 1; n <= 18; n += 17) begin
                @(posedge clock_i);
                boot_reset_select_fuse_i <= 1'b0;
                boot_size_fuses_i <= 2'(s);
                irq_num_i <= 5'(n);
                step(2);
                check("vector address", 16'(irq_vector_addr_o), 16'(bstart[s] + 12'(n)));
                check("boot reset address", 16'(reset_addr_o), 16'(bstart[s]));
            end
        end
        $display("test vector_map done");
        // Lock masking with vectors in boot, then in application
        // Inputs move only on a rising edge; vector number is still 18 here
        @(posedge clock_i);
        boot_size_fuses_i <= IVR_SZ_1K;
        app_section_boot_lock_i <= 1'b0;
        pc_i <= 12'h010;
        step(2);
        check("app code masked", 16'(irq_enable_o), 16'h0);
        @(posedge clock_i);
        pc_i <= 12'hc10;
        step(2);
        check("boot code open", 16'(irq_enable_o), 16'h1);
        @(posedge clock_i);
        app_section_boot_lock_i <= 1'b1;
        wr(IVR_GIC_OFS, 8'h01);
        wr(IVR_GIC_OFS, 8'h00);
        wait_enable();
        @(posedge clock_i);
        boot_section_boot_lock_i <= 1'b0;
        step(2);
        check("boot code masked", 16'(irq_enable_o), 16'h0);
        @(posedge clock_i);
        pc_i <= 12'h010;
        step(2);
        check("app code open", 16'(irq_enable_o), 16'h1);
        check("vector back at flash", 16'(irq_vector_addr_o), 16'h12);
        $display("test lock_masking done");
        complete_run();
    end
endmodule : interrupt_vector_relocation_test
`default_nettype wire
